// ### logic/tdt_defines.vh
/*
 * Constants for the 8-bit timer/counter: register indices, field positions,
 * reset values, mode codes and prescaler taps.
 * Assumes a byte address of four times the register index on the bus.
 */
`ifndef TDT_DEFINES_VH
`define TDT_DEFINES_VH

// Register indices (byte address = 4 * index)
`define TDT_IDX_CTLA 8'hB0
`define TDT_IDX_CTLB 8'hB1
`define TDT_IDX_CNT 8'hB2
`define TDT_IDX_OCRA 8'hB3
`define TDT_IDX_OCRB 8'hB4
`define TDT_IDX_ASYNC_CLOCK_STATUS 8'hB6
`define TDT_IDX_GTC 8'hB8
`define TDT_IDX_FLAG 8'hB9
`define TDT_IDX_PINSEL 8'hBA

`define TDT_REG_RESET 8'h00
`define TDT_TOP_FIXED 8'hFF

// Field positions
`define TDT_CTLB_FOCA 7
`define TDT_CTLB_FOCB 6
`define TDT_CTLB_WGM2 3
`define TDT_ASYNC_CLOCK_STATUS_ALT 7
`define TDT_ASYNC_CLOCK_STATUS_EXTERNAL_CLOCK_INPUT_ENABLE 6
`define TDT_ASYNC_CLOCK_STATUS_AS 5
`define TDT_GTC_TSM 7
`define TDT_GTC_ASYNC_PRESCALER_RESET 1
`define TDT_GTC_SYNC_PRESCALER_RESET 0

// Update-busy bit positions, also the temporary storage slots
`define TDT_UB_CNT 4
`define TDT_UB_OCRA 3
`define TDT_UB_OCRB 2
`define TDT_UB_CTLA 1
`define TDT_UB_CTLB 0

// Waveform modes
`define TDT_WGM_NORMAL 3'h0
`define TDT_WGM_PC_FF 3'h1
`define TDT_WGM_CTC 3'h2
`define TDT_WGM_FAST_FF 3'h3
`define TDT_WGM_PC_OCRA 3'h5
`define TDT_WGM_FAST_OCRA 3'h7

// Channel output modes
`define TDT_COM_OFF 2'h0
`define TDT_COM_TOGGLE 2'h1
`define TDT_COM_CLEAR 2'h2
`define TDT_COM_SET 2'h3

// Clock select codes and prescaler masks
`define TDT_CS_STOP 3'h0
`define TDT_CS_DIV1 3'h1
`define TDT_CS_DIV8 3'h2
`define TDT_CS_DIV32 3'h3
`define TDT_CS_DIV64 3'h4
`define TDT_CS_DIV128 3'h5
`define TDT_CS_DIV256 3'h6
`define TDT_MASK_8 10'h007
`define TDT_MASK_32 10'h01F
`define TDT_MASK_64 10'h03F
`define TDT_MASK_128 10'h07F
`define TDT_MASK_256 10'h0FF
`define TDT_MASK_1024 10'h3FF

// Bus responses
`define TDT_RESP_OKAY 2'h0
`define TDT_RESP_SLVERR 2'h2

`endif

// ### logic/tdt_prescaler.v
/*
 * Prescaler for the timer: divides the source tick by the clock select.
 * Assumes i_src_tick is a one-cycle enable on i_clk_sys.
 */
`include "tdt_defines.vh"

module tdt_prescaler (
	input wire i_clk_sys,
	input wire i_nrst,
	input wire i_src_tick,
	input wire i_hold,
	input wire [2:0] i_sel,
	output wire o_tick
);

reg [9:0] div_reg;

function [9:0] tap_mask;
	input [2:0] sel;
	begin
		case (sel)
			`TDT_CS_DIV8: tap_mask = `TDT_MASK_8;
			`TDT_CS_DIV32: tap_mask = `TDT_MASK_32;
			`TDT_CS_DIV64: tap_mask = `TDT_MASK_64;
			`TDT_CS_DIV128: tap_mask = `TDT_MASK_128;
			`TDT_CS_DIV256: tap_mask = `TDT_MASK_256;
			default: tap_mask = `TDT_MASK_1024;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Free-running divider; held at zero while the prescaler reset is asserted
always @(posedge i_clk_sys or negedge i_nrst) begin
	if (!i_nrst) begin
		div_reg <= 10'h000;
	end else if (i_hold) begin
		div_reg <= 10'h000;
	end else if (i_src_tick) begin
		div_reg <= div_reg + 10'h001;
	end
end

// Stopped, undivided, or tap at the all-ones point of the mask
assign o_tick = ~i_hold & i_src_tick & (i_sel != `TDT_CS_STOP) &
	((i_sel == `TDT_CS_DIV1) | ((div_reg & tap_mask(i_sel)) == tap_mask(i_sel)));

endmodule

// ### logic/tdt_timer.v
/*
 * 8-bit timer/counter with two compare channels, waveform modes, clock
 * source selection, prescaler reset control and an AXI4-Lite register port.
 * Assumes external clock pins are slow against i_clk_sys (below half rate);
 * they are synchronised and edge-detected, so the block keeps one clock.
 */
// The AXI4-Lite register port was decided locally.
`include "tdt_defines.vh"

// Operation
// - Mode 0 normal, 1/5 phase-correct PWM, 2 clear-on-match, 3/7 fast PWM.
// - Force-compare in non-PWM modes applies a channel's output action at once.
// - Forced compare sets no flag, never clears counter, reads back zero.
// - Clock select stops, passes, or divides source by 8..1024.
// - Count pin edges clock the counter even if the pin drives out.
// - Counter is read/write; a write blocks the next compare match.
// - Both compare values match the counter continuously for flag and output.
// - Async select clear runs on system clock, set runs from oscillator pin.
// - Changing async select may corrupt timer registers; software rewrites them.
// - External clock bit takes a driven clock; crystal runs only when clear.
// - Alternate-clock enable with async select clocks from the alternate pin.
// - Async writes set per-register busy flags, cleared once transferred.
// - Hold mode keeps prescaler resets asserted; clearing it releases both.
// - Async prescaler reset clears at once, or on the next source tick when async.
// - Non-PWM output modes: off, toggle, clear, set on match.
// - Flags set on events, cleared by acknowledge or writing one.
module tdt_timer #(
	parameter AW = 10
) (
	input wire i_clk_sys,
	input wire i_nrst,
	input wire [AW-1:0] i_s_axi_awaddr,
	input wire i_s_axi_awvalid,
	output reg o_s_axi_awready,
	input wire [31:0] i_s_axi_wdata,
	input wire [3:0] i_s_axi_wstrb,
	input wire i_s_axi_wvalid,
	output reg o_s_axi_wready,
	output reg [1:0] o_s_axi_bresp,
	output reg o_s_axi_bvalid,
	input wire i_s_axi_bready,
	input wire [AW-1:0] i_s_axi_araddr,
	input wire i_s_axi_arvalid,
	output reg o_s_axi_arready,
	output reg [31:0] o_s_axi_rdata,
	output reg [1:0] o_s_axi_rresp,
	output reg o_s_axi_rvalid,
	input wire i_s_axi_rready,
	input wire i_osc_pin,
	input wire i_alt_clk_pin,
	input wire i_count_pin,
	input wire [2:0] i_flag_ack,
	output reg o_wave_a,
	output reg o_wave_a_oe,
	output reg o_wave_b,
	output reg o_wave_b_oe,
	output reg o_crystal_en,
	output reg o_sync_prescaler_reset
);

reg aw_full_reg;
reg w_full_reg;
reg [7:0] awidx_reg;
reg [7:0] wdata_reg;
reg wstrb0_reg;
reg [7:0] ctla_reg;
reg [5:0] ctlb_reg;
reg [7:0] cnt_reg;
reg [7:0] ocra_reg;
reg [7:0] ocrb_reg;
reg [7:5] clkctl_reg;
reg [4:0] busy_reg;
reg [7:0] tmp_reg [0:4];
reg tsm_reg;
reg psra_reg;
reg [2:0] flag_reg;
reg pinsel_reg;
reg block_reg;
reg up_reg;
reg [2:0] osc_sync_reg;
reg [2:0] alt_sync_reg;
reg [2:0] pin_sync_reg;
reg [7:0] cnt_next;
reg up_next;
reg tov;
reg bot;
reg [7:0] rd_val;
integer k;

// Address decode shared by read and write
function addr_ok;
	input [7:0] idx;
	begin
		case (idx)
			`TDT_IDX_CTLA, `TDT_IDX_CTLB, `TDT_IDX_CNT, `TDT_IDX_OCRA, `TDT_IDX_OCRB,
			`TDT_IDX_ASYNC_CLOCK_STATUS, `TDT_IDX_GTC, `TDT_IDX_FLAG, `TDT_IDX_PINSEL: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
endfunction

// New level of a channel output after a match or a bottom event
function wave_fn;
	input cur;
	input [1:0] com;
	input mt;
	input bt;
	input up;
	input [2:0] wgm;
	input is_a;
	begin
		wave_fn = cur;
		if (!wgm[0]) begin
			if (mt) begin
				case (com)
					`TDT_COM_TOGGLE: wave_fn = ~cur;
					`TDT_COM_CLEAR: wave_fn = 1'b0;
					`TDT_COM_SET: wave_fn = 1'b1;
					default: wave_fn = cur;
				endcase
			end
		end else if (com == `TDT_COM_TOGGLE) begin
			if (is_a && wgm[2] && mt) begin
				wave_fn = ~cur;
			end
		end else if (com != `TDT_COM_OFF) begin
			// Fast PWM: match and bottom; phase-correct: up and down matches
			if (mt) begin
				wave_fn = (wgm[1] | ~up) ^ (com == `TDT_COM_CLEAR);
			end else if (bt) begin
				wave_fn = (com == `TDT_COM_CLEAR);
			end
		end
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Bus write side

wire wr_do = aw_full_reg & w_full_reg & ~o_s_axi_bvalid;
wire wr_en = wr_do & wstrb0_reg & addr_ok(awidx_reg);
wire wr_ctla = wr_en & (awidx_reg == `TDT_IDX_CTLA);
wire wr_ctlb = wr_en & (awidx_reg == `TDT_IDX_CTLB);
wire wr_cnt = wr_en & (awidx_reg == `TDT_IDX_CNT);
wire wr_ocra = wr_en & (awidx_reg == `TDT_IDX_OCRA);
wire wr_ocrb = wr_en & (awidx_reg == `TDT_IDX_OCRB);
wire wr_async_clock_status = wr_en & (awidx_reg == `TDT_IDX_ASYNC_CLOCK_STATUS);
wire wr_gtc = wr_en & (awidx_reg == `TDT_IDX_GTC);
wire wr_flag = wr_en & (awidx_reg == `TDT_IDX_FLAG);
wire wr_pinsel = wr_en & (awidx_reg == `TDT_IDX_PINSEL);
wire [4:0] wr_q = {wr_cnt, wr_ocra, wr_ocrb, wr_ctla, wr_ctlb};

// Address and data are latched independently; the write fires once both are in
always @(posedge i_clk_sys or negedge i_nrst) begin
	if (!i_nrst) begin
		aw_full_reg <= 1'b0;
		w_full_reg <= 1'b0;
		o_s_axi_awready <= 1'b1;
		o_s_axi_wready <= 1'b1;
		awidx_reg <= 8'h00;
		wdata_reg <= 8'h00;
		wstrb0_reg <= 1'b0;
		o_s_axi_bvalid <= 1'b0;
		o_s_axi_bresp <= `TDT_RESP_OKAY;
	end else begin
		if (i_s_axi_awvalid && o_s_axi_awready) begin
			aw_full_reg <= 1'b1;
			o_s_axi_awready <= 1'b0;
			awidx_reg <= i_s_axi_awaddr[9:2];
		end
		if (i_s_axi_wvalid && o_s_axi_wready) begin
			w_full_reg <= 1'b1;
			o_s_axi_wready <= 1'b0;
			wdata_reg <= i_s_axi_wdata[7:0];
			wstrb0_reg <= i_s_axi_wstrb[0];
		end
		if (wr_do) begin
			o_s_axi_bvalid <= 1'b1;
			o_s_axi_bresp <= addr_ok(awidx_reg) ? `TDT_RESP_OKAY : `TDT_RESP_SLVERR;
		end
		// Channels reopen only after the response is taken: one write at a time
		if (o_s_axi_bvalid && i_s_axi_bready) begin
			o_s_axi_bvalid <= 1'b0;
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			o_s_axi_awready <= 1'b1;
			o_s_axi_wready <= 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Clock source selection

// Pins pass two flops before the edge detector looks at them
always @(posedge i_clk_sys or negedge i_nrst) begin
	if (!i_nrst) begin
		osc_sync_reg <= 3'h0;
		alt_sync_reg <= 3'h0;
		pin_sync_reg <= 3'h0;
	end else begin
		osc_sync_reg <= {osc_sync_reg[1:0], i_osc_pin};
		alt_sync_reg <= {alt_sync_reg[1:0], i_alt_clk_pin};
		pin_sync_reg <= {pin_sync_reg[1:0], i_count_pin};
	end
end

wire as_mode = clkctl_reg[`TDT_ASYNC_CLOCK_STATUS_AS];
wire osc_rise = osc_sync_reg[1] & ~osc_sync_reg[2];
wire alt_rise = alt_sync_reg[1] & ~alt_sync_reg[2];
wire pin_rise = pin_sync_reg[1] & ~pin_sync_reg[2];

// Pin input is read even when the pad drives out, so software can count
wire src_tick = pinsel_reg ? pin_rise :
	as_mode ? (clkctl_reg[`TDT_ASYNC_CLOCK_STATUS_ALT] ? alt_rise : osc_rise) :
	1'b1;

wire tick;

tdt_prescaler u_presc (
	.i_clk_sys(i_clk_sys),
	.i_nrst(i_nrst),
	.i_src_tick(src_tick),
	.i_hold(psra_reg),
	.i_sel(ctlb_reg[2:0]),
	.o_tick(tick)
);

////////////////////////////////////////////////////////////////////////////////
// Async transfer: writes park in temporary storage until a source tick

wire [4:0] commit = as_mode ? (busy_reg & {5{src_tick}}) : wr_q;
wire [7:0] v_cnt = as_mode ? tmp_reg[`TDT_UB_CNT] : wdata_reg;
wire [7:0] v_ocra = as_mode ? tmp_reg[`TDT_UB_OCRA] : wdata_reg;
wire [7:0] v_ocrb = as_mode ? tmp_reg[`TDT_UB_OCRB] : wdata_reg;
wire [7:0] v_ctla = as_mode ? tmp_reg[`TDT_UB_CTLA] : wdata_reg;
wire [7:0] v_ctlb = as_mode ? tmp_reg[`TDT_UB_CTLB] : wdata_reg;

////////////////////////////////////////////////////////////////////////////////
// Counting sequence

wire [2:0] wgm = {ctlb_reg[`TDT_CTLB_WGM2], ctla_reg[1:0]};
wire phase = (wgm == `TDT_WGM_PC_FF) | (wgm == `TDT_WGM_PC_OCRA);
wire ocra_top = (wgm == `TDT_WGM_CTC) | (wgm == `TDT_WGM_PC_OCRA) | (wgm == `TDT_WGM_FAST_OCRA);
wire [7:0] top = ocra_top ? ocra_reg : `TDT_TOP_FIXED;
wire at_top = (cnt_reg == top);
wire mt_a = tick & ~block_reg & (cnt_reg == ocra_reg);
wire mt_b = tick & ~block_reg & (cnt_reg == ocrb_reg);
// Forces act in non-PWM modes only (all PWM codes are odd)
wire frc_a = commit[`TDT_UB_CTLB] & v_ctlb[`TDT_CTLB_FOCA] & ~wgm[0];
wire frc_b = commit[`TDT_UB_CTLB] & v_ctlb[`TDT_CTLB_FOCB] & ~wgm[0];

always @* begin
	cnt_next = cnt_reg;
	up_next = up_reg;
	tov = 1'b0;
	bot = 1'b0;
	if (commit[`TDT_UB_CNT]) begin
		cnt_next = v_cnt;
	end else if (tick && phase) begin
		if (up_reg && at_top) begin
			up_next = 1'b0;
			cnt_next = cnt_reg - 8'h01;
		end else if (!up_reg && cnt_reg == 8'h00) begin
			up_next = 1'b1;
			cnt_next = 8'h01;
			tov = 1'b1; // Direction change at bottom
		end else begin
			cnt_next = up_reg ? cnt_reg + 8'h01 : cnt_reg - 8'h01;
		end
	end else if (tick) begin
		// Forced compares never reach this clear
		cnt_next = at_top ? 8'h00 : cnt_reg + 8'h01;
		tov = wgm[0] ? at_top : (cnt_reg == `TDT_TOP_FIXED);
		bot = at_top;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Timer state, control and flags

always @(posedge i_clk_sys or negedge i_nrst) begin
	if (!i_nrst) begin
		ctla_reg <= `TDT_REG_RESET;
		ctlb_reg <= 6'h00;
		cnt_reg <= `TDT_REG_RESET;
		ocra_reg <= `TDT_REG_RESET;
		ocrb_reg <= `TDT_REG_RESET;
		clkctl_reg <= 3'h0;
		busy_reg <= 5'h00;
		for (k = 0; k < 5; k = k + 1) begin
			tmp_reg[k] <= `TDT_REG_RESET;
		end
		tsm_reg <= 1'b0;
		psra_reg <= 1'b0;
		o_sync_prescaler_reset <= 1'b0;
		flag_reg <= 3'h0;
		pinsel_reg <= 1'b0;
		block_reg <= 1'b0;
		up_reg <= 1'b1;
		o_wave_a <= 1'b0;
		o_wave_b <= 1'b0;
		o_wave_a_oe <= 1'b0;
		o_wave_b_oe <= 1'b0;
		o_crystal_en <= 1'b0;
	end else begin
		for (k = 0; k < 5; k = k + 1) begin
			if (wr_q[k]) begin
				tmp_reg[k] <= wdata_reg;
			end
		end
		// A write in the transfer cycle keeps its flag set
		busy_reg <= as_mode ? (wr_q | (busy_reg & ~{5{src_tick}})) : 5'h00;
		if (commit[`TDT_UB_CTLA]) ctla_reg <= v_ctla;
		if (commit[`TDT_UB_CTLB]) ctlb_reg <= v_ctlb[5:0]; // Force bits not stored
		if (commit[`TDT_UB_OCRA]) ocra_reg <= v_ocra;
		if (commit[`TDT_UB_OCRB]) ocrb_reg <= v_ocrb;
		cnt_reg <= cnt_next;
		up_reg <= up_next;
		// Block lasts until the next timer clock after a counter write
		block_reg <= commit[`TDT_UB_CNT] | (block_reg & ~tick);
		// Contents are not repaired on a source change; software rewrites
		if (wr_async_clock_status) clkctl_reg <= wdata_reg[7:5];
		o_crystal_en <= clkctl_reg[`TDT_ASYNC_CLOCK_STATUS_AS] & ~clkctl_reg[`TDT_ASYNC_CLOCK_STATUS_EXTERNAL_CLOCK_INPUT_ENABLE] &
			~clkctl_reg[`TDT_ASYNC_CLOCK_STATUS_ALT];
		if (wr_pinsel) pinsel_reg <= wdata_reg[0];
		// Hold mode: written resets stay; clearing hold drops both
		if (wr_gtc) begin
			tsm_reg <= wdata_reg[`TDT_GTC_TSM];
			psra_reg <= (tsm_reg & ~wdata_reg[`TDT_GTC_TSM]) ? 1'b0 : wdata_reg[`TDT_GTC_ASYNC_PRESCALER_RESET];
			o_sync_prescaler_reset <= (tsm_reg & ~wdata_reg[`TDT_GTC_TSM]) ? 1'b0 :
				wdata_reg[`TDT_GTC_SYNC_PRESCALER_RESET];
		end else if (!tsm_reg) begin
			// Async: the reset completes on the next source tick
			if (!as_mode || src_tick) psra_reg <= 1'b0;
			o_sync_prescaler_reset <= 1'b0;
		end
		// Set wins over a same-cycle clear; forced compares set nothing
		flag_reg <= (flag_reg & ~(i_flag_ack | ({3{wr_flag}} & wdata_reg[2:0]))) |
			{mt_b, mt_a, tov};
		o_wave_a <= wave_fn(o_wave_a, ctla_reg[7:6], mt_a | frc_a, bot & tick,
			up_reg, wgm, 1'b1);
		o_wave_b <= wave_fn(o_wave_b, ctla_reg[5:4], mt_b | frc_b, bot & tick,
			up_reg, wgm, 1'b0);
		o_wave_a_oe <= (ctla_reg[7:6] != `TDT_COM_OFF);
		o_wave_b_oe <= (ctla_reg[5:4] != `TDT_COM_OFF);
	end
end

////////////////////////////////////////////////////////////////////////////////
// Bus read side: data captured at the address handshake

always @* begin
	case (i_s_axi_araddr[9:2])
		`TDT_IDX_CTLA: rd_val = ctla_reg;
		`TDT_IDX_CTLB: rd_val = {2'b00, ctlb_reg}; // Force bits read zero
		`TDT_IDX_CNT: rd_val = cnt_reg;
		`TDT_IDX_OCRA: rd_val = ocra_reg;
		`TDT_IDX_OCRB: rd_val = ocrb_reg;
		`TDT_IDX_ASYNC_CLOCK_STATUS: rd_val = {clkctl_reg, busy_reg};
		`TDT_IDX_GTC: rd_val = {tsm_reg, 5'h00, psra_reg, o_sync_prescaler_reset};
		`TDT_IDX_FLAG: rd_val = {5'h00, flag_reg};
		`TDT_IDX_PINSEL: rd_val = {7'h00, pinsel_reg};
		default: rd_val = 8'h00;
	endcase
end

always @(posedge i_clk_sys or negedge i_nrst) begin
	if (!i_nrst) begin
		o_s_axi_arready <= 1'b1;
		o_s_axi_rvalid <= 1'b0;
		o_s_axi_rdata <= 32'h00000000;
		o_s_axi_rresp <= `TDT_RESP_OKAY;
	end else if (i_s_axi_arvalid && o_s_axi_arready) begin
		o_s_axi_arready <= 1'b0;
		o_s_axi_rvalid <= 1'b1;
		o_s_axi_rdata <= {24'h000000, rd_val};
		o_s_axi_rresp <= addr_ok(i_s_axi_araddr[9:2]) ? `TDT_RESP_OKAY : `TDT_RESP_SLVERR;
	end else if (o_s_axi_rvalid && i_s_axi_rready) begin
		o_s_axi_rvalid <= 1'b0;
		o_s_axi_arready <= 1'b1;
	end
end

endmodule

// ### verification/tdt_timer_checker.sv
/*
 * Concurrent checks on the timer's register port and pin-side outputs.
 * Assumes the master offers write address and data together.
 */
`include "tdt_defines.vh"

module tdt_timer_checker #(
	parameter AW = 10
) (
	input wire i_clk_sys,
	input wire i_nrst,
	input wire [AW-1:0] i_s_axi_awaddr,
	input wire i_s_axi_awvalid,
	input wire o_s_axi_awready,
	input wire [31:0] i_s_axi_wdata,
	input wire [3:0] i_s_axi_wstrb,
	input wire i_s_axi_wvalid,
	input wire o_s_axi_wready,
	input wire [1:0] o_s_axi_bresp,
	input wire o_s_axi_bvalid,
	input wire [AW-1:0] i_s_axi_araddr,
	input wire i_s_axi_arvalid,
	input wire o_s_axi_arready,
	input wire [31:0] o_s_axi_rdata,
	input wire o_s_axi_rvalid,
	input wire o_wave_a_oe,
	input wire o_wave_b_oe,
	input wire o_crystal_en,
	input wire o_sync_prescaler_reset
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);

	////////////////////////////////////////////////////////////////
	// Decoded write, kept combinational so $past can look back at it
	wire take = i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
	wire wr_go = take && i_s_axi_wstrb[0];
	wire [7:0] w_idx = i_s_axi_awaddr[AW-1:2];
	wire [7:0] w_dat = i_s_axi_wdata[7:0];
	wire mapped = (w_idx >= `TDT_IDX_CTLA) && (w_idx <= `TDT_IDX_PINSEL) && (w_idx != 8'hB5) && (w_idx != 8'hB7);
	wire xtal_want = w_dat[5] && !w_dat[6] && !w_dat[7];
	wire [1:0] oe_want = {|w_dat[7:6], |w_dat[5:4]};
	reg [7:0] r_idx_reg;
	reg as_reg;

	// Async mode defers control writes, so output-enable timing is only checked in sync mode
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			r_idx_reg <= 8'h00;
			as_reg <= 1'b0;
		end else begin
			if (i_s_axi_arvalid && o_s_axi_arready)
				r_idx_reg <= i_s_axi_araddr[AW-1:2];
			if (wr_go && w_idx == `TDT_IDX_ASYNC_CLOCK_STATUS)
				as_reg <= w_dat[`TDT_ASYNC_CLOCK_STATUS_AS];
		end
	end

	////////////////////////////////////////////////////////////////
	// The write lands one edge after both channels are taken, so the answer shows a cycle later
	write_answer_a: assert property (take |=> ##1 o_s_axi_bvalid)
		else $error("write response missing");
	write_resp_a: assert property (take |=> ##1 o_s_axi_bresp == (mapped ? `TDT_RESP_OKAY : `TDT_RESP_SLVERR))
		else $error("write response code wrong");
	read_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid && !o_s_axi_arready)
		else $error("read answer missing");
	read_upper_a: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	force_readzero_a: assert property (o_s_axi_rvalid && r_idx_reg == `TDT_IDX_CTLB |-> o_s_axi_rdata[7:6] == 2'h0)
		else $error("force bits read back");
	hold_keeps_a: assert property (wr_go && w_idx == `TDT_IDX_GTC && w_dat[7] && w_dat[0] |=>
		##1 o_sync_prescaler_reset [*2])
		else $error("held prescaler reset dropped");
	hold_release_a: assert property (wr_go && w_idx == `TDT_IDX_GTC && !w_dat[7] && !w_dat[0] |=>
		##1 !o_sync_prescaler_reset)
		else $error("prescaler reset not released");
	crystal_run_a: assert property (wr_go && w_idx == `TDT_IDX_ASYNC_CLOCK_STATUS |=> ##2 o_crystal_en == $past(xtal_want, 3))
		else $error("crystal enable wrong");
	oe_follow_a: assert property (wr_go && w_idx == `TDT_IDX_CTLA && !as_reg |=>
		##2 {o_wave_a_oe, o_wave_b_oe} == $past(oe_want, 3))
		else $error("output enable wrong");
endmodule

bind tdt_timer tdt_timer_checker #(.AW(AW)) i_chk (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
	.i_s_axi_awaddr(i_s_axi_awaddr), .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
	.i_s_axi_wdata(i_s_axi_wdata), .i_s_axi_wstrb(i_s_axi_wstrb), .i_s_axi_wvalid(i_s_axi_wvalid),
	.o_s_axi_wready(o_s_axi_wready), .o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid),
	.i_s_axi_araddr(i_s_axi_araddr), .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
	.o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rvalid(o_s_axi_rvalid), .o_wave_a_oe(o_wave_a_oe),
	.o_wave_b_oe(o_wave_b_oe), .o_crystal_en(o_crystal_en), .o_sync_prescaler_reset(o_sync_prescaler_reset));

// ### verification/tdt_timer_tb.sv
/*
 * Self-checking bench for the timer: register port, waveform outputs,
 * prescaler, pin clocking, async busy flags and prescaler reset control.
 * Assumes a 25 MHz system clock and slow pin edges.
 */
`include "tdt_defines.vh"

module tdt_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, nrst = 0;
	logic [9:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0;
	logic [3:0] wstrb = 0;
	logic osc = 0, alt = 0, cpin = 0;
	logic [2:0] ack = 0;
	wire awready, wready, bvalid, arready, rvalid, wa, wa_oe, wb, wb_oe, xtal, psr;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	int num_errors = 0, check_count = 0;
	logic [31:0] rv;
	logic [1:0] rs, bs;
	logic [7:0] d;
	logic [7:0] ids [8] = '{8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB6, 8'hB8, 8'hB9};
	int dv [6] = '{8, 32, 64, 128, 256, 1024};

	tdt_timer #(.AW(10)) i_dut (.i_clk_sys(clk), .i_nrst(nrst), .i_s_axi_awaddr(awaddr),
		.i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
		.i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
		.i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
		.o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
		.i_osc_pin(osc), .i_alt_clk_pin(alt), .i_count_pin(cpin), .i_flag_ack(ack), .o_wave_a(wa),
		.o_wave_a_oe(wa_oe), .o_wave_b(wb), .o_wave_b_oe(wb_oe), .o_crystal_en(xtal),
		.o_sync_prescaler_reset(psr));

	always #20 clk = ~clk;

	////////////////////////////////////////////////////////////////
	// Bus master: each channel is released at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s = 4'h1);
		@(posedge clk);
		awaddr <= {a, 2'b00};
		wdata <= {24'h0, v};
		wstrb <= s;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		// No cycle limit here: only the hang guard ends a wait
		do begin
			@(posedge clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (bvalid !== 1'b1);
		bs = bresp;
		bready <= 0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= {a, 2'b00};
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 0;
		end while (rvalid !== 1'b1);
		rv = rdata;
		rs = rresp;
		rready <= 0;
	endtask

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Pin pulses: 0 count pin, 1 oscillator pin, 2 alternate pin; idle low between pulses
	task automatic tick(input int w, input int n);
		repeat (n) begin
			@(posedge clk);
			if (w == 0) cpin <= 1;
			else if (w == 1) osc <= 1;
			else alt <= 1;
			repeat (4) @(posedge clk);
			cpin <= 0;
			osc <= 0;
			alt <= 0;
			repeat (4) @(posedge clk);
		end
	endtask

	task stop_test();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Hang guard, well beyond the roughly 7k cycles the sequence needs
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		stop_test();
	end

	initial begin
		rv = $urandom(86844);
		repeat (16) @(posedge clk);
		nrst <= 1;
		foreach (ids[i]) begin
			rd(ids[i]);
			chk("reset value", rv, 0);
		end
		rd(8'h10);
		chk("unmapped read", {rs, rv[29:0]}, {`TDT_RESP_SLVERR, 30'h0});
		wr(8'h10, 8'hFF);
		chk("unmapped write", bs, `TDT_RESP_SLVERR);
		for (int i = 2; i < 5; i++) begin
			d = $urandom;
			wr(8'hB0 + i, d);
			rd(8'hB0 + i);
			chk("read back", rv, d);
		end
		// Forced compares: A toggle, B set, then A set, B clear
		wr(`TDT_IDX_CTLA, 8'h70);
		wr(`TDT_IDX_CTLB, 8'hC0);
		repeat (2) @(posedge clk);
		chk("force wave", {wa, wb}, 2'b11);
		rd(`TDT_IDX_CTLB);
		chk("force readback", rv, 0);
		rd(`TDT_IDX_FLAG);
		chk("force flags", rv, 0);
		wr(`TDT_IDX_CTLB, 8'h80);
		repeat (2) @(posedge clk);
		chk("toggle back", {wa, wb}, 2'b01);
		wr(`TDT_IDX_CTLA, 8'hE0);
		wr(`TDT_IDX_CTLB, 8'hC0);
		repeat (2) @(posedge clk);
		chk("set clear", {wa, wb}, 2'b10);
		// Free counting across the wrap, then clear by acknowledge
		wr(`TDT_IDX_CNT, 8'hF0);
		wr(`TDT_IDX_CTLB, 8'h01);
		repeat (40) @(posedge clk);
		wr(`TDT_IDX_CTLB, 8'h00);
		rd(`TDT_IDX_FLAG);
		chk("overflow", rv[0], 1);
		@(posedge clk);
		ack <= 3'h1;
		@(posedge clk);
		ack <= 3'h0;
		rd(`TDT_IDX_FLAG);
		chk("ack clear", rv[0], 0);
		rd(`TDT_IDX_CNT);
		d = rv[7:0];
		repeat (20) @(posedge clk);
		rd(`TDT_IDX_CNT);
		chk("stopped", rv, d);
		// Each prescaler tap over four of its periods; phase allows one count either way
		foreach (dv[i]) begin
			wr(`TDT_IDX_CNT, 8'h00);
			wr(`TDT_IDX_CTLB, i + 2);
			repeat (4 * dv[i]) @(posedge clk);
			wr(`TDT_IDX_CTLB, 8'h00);
			rd(`TDT_IDX_CNT);
			chk("prescale", rv >= 3 && rv <= 5, 1);
		end
		// Count pin clocking, compare A clearing the output on the fourth tick
		wr(`TDT_IDX_PINSEL, 8'h01);
		wr(`TDT_IDX_OCRA, 8'h03);
		wr(`TDT_IDX_CTLA, 8'hC0);
		wr(`TDT_IDX_CTLB, 8'h81);
		wr(`TDT_IDX_CTLA, 8'h80);
		wr(`TDT_IDX_CNT, 8'h00);
		wr(`TDT_IDX_FLAG, 8'h07);
		tick(0, 3);
		chk("before match", wa, 1);
		tick(0, 1);
		chk("after match", wa, 0);
		rd(`TDT_IDX_CNT);
		chk("pin count", rv, 4);
		rd(`TDT_IDX_FLAG);
		chk("match flag", rv[1], 1);
		wr(`TDT_IDX_FLAG, 8'h02);
		rd(`TDT_IDX_FLAG);
		chk("flag clear", rv[1], 0);
		wr(`TDT_IDX_CNT, 8'h03);
		tick(0, 1);
		rd(`TDT_IDX_FLAG);
		chk("blocked match", rv[1], 0);
		wr(`TDT_IDX_CTLA, 8'h02);
		wr(`TDT_IDX_OCRA, 8'h05);
		wr(`TDT_IDX_CNT, 8'h00);
		tick(0, 7);
		rd(`TDT_IDX_CNT);
		chk("clear on match", rv, 1);
		wr(`TDT_IDX_CNT, 8'hAA, 4'h0);
		rd(`TDT_IDX_CNT);
		chk("strobe off", rv, 1);
		// Phase-correct with top from compare A: 0,1,2,3 then back down to 1; force bits kept zero
		wr(`TDT_IDX_CTLA, 8'h01);
		wr(`TDT_IDX_CTLB, 8'h09);
		wr(`TDT_IDX_OCRA, 8'h03);
		wr(`TDT_IDX_CNT, 8'h00);
		tick(0, 5);
		rd(`TDT_IDX_CNT);
		chk("phase count", rv, 1);
		wr(`TDT_IDX_PINSEL, 8'h00);
		wr(`TDT_IDX_CTLB, 8'h00);
		// Async writes park in temporary storage; one clock bit changed per write
		wr(`TDT_IDX_ASYNC_CLOCK_STATUS, 8'h20);
		d = $urandom;
		wr(`TDT_IDX_OCRB, d);
		rd(`TDT_IDX_ASYNC_CLOCK_STATUS);
		chk("busy set", rv, 8'h24);
		tick(1, 1);
		rd(`TDT_IDX_ASYNC_CLOCK_STATUS);
		chk("busy clear", rv, 8'h20);
		rd(`TDT_IDX_OCRB);
		chk("async value", rv, d);
		wr(`TDT_IDX_ASYNC_CLOCK_STATUS, 8'hA0);
		wr(`TDT_IDX_CNT, 8'h11);
		rd(`TDT_IDX_ASYNC_CLOCK_STATUS);
		chk("alt busy", rv, 8'hB0);
		tick(2, 1);
		rd(`TDT_IDX_ASYNC_CLOCK_STATUS);
		chk("alt clear", rv, 8'hA0);
		rd(`TDT_IDX_CNT);
		chk("alt value", rv, 8'h11);
		wr(`TDT_IDX_ASYNC_CLOCK_STATUS, 8'h20);
		wr(`TDT_IDX_ASYNC_CLOCK_STATUS, 8'h60);
		wr(`TDT_IDX_ASYNC_CLOCK_STATUS, 8'h40);
		wr(`TDT_IDX_ASYNC_CLOCK_STATUS, 8'h00);
		// Hold mode keeps both resets; release clears them
		wr(`TDT_IDX_GTC, 8'h81);
		wr(`TDT_IDX_GTC, 8'h83);
		rd(`TDT_IDX_GTC);
		chk("held resets", rv, 8'h83);
		wr(`TDT_IDX_GTC, 8'h00);
		rd(`TDT_IDX_GTC);
		chk("released", rv, 0);
		wr(`TDT_IDX_GTC, 8'h02);
		rd(`TDT_IDX_GTC);
		chk("self clear", rv, 0);
		stop_test();
	end
endmodule
